//--- hw/tli_handler.sv
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ns
`include "tli_params.svh"


module tli_handler (
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic [`TLI_NSRC-1:0] SRC_EVENT_I,
  input wire tli_pkg::tli_cpu_type CPU_I,
  input wire logic [`TLI_AW-1:0] ADDR_I,
  input wire logic [`TLI_DW-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [`TLI_DW-1:0] RDATA_O,
  output tli_pkg::tli_call_type CALL_O,
  output logic VEC_REQ_O,
  output logic IRQ_O
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [3:0] tli_first_idx(input logic [`TLI_NSRC-1:0] v);
    logic [3:0] r;
    r = '0;
    for (int i = `TLI_NSRC - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : tli_first_idx

  // Main byte carries sources 6..0, extended byte sources 11..7
  function automatic logic [`TLI_NSRC-1:0] tli_join(input logic [`TLI_NSRC-1:0] cur,
                                                    input logic [`TLI_DW-1:0] d,
                                                    input logic ext);
    logic [`TLI_NSRC-1:0] r;
    r = cur;
    if (ext)
    begin
      r[`TLI_NSRC-1:`TLI_MAIN_N] = d[`TLI_EXT_N-1:0];
    end
    else
    begin
      r[`TLI_MAIN_N-1:0] = d[`TLI_MAIN_N-1:0];
    end
    return r;
  endfunction : tli_join

  function automatic logic [`TLI_DW-1:0] tli_split(input logic [`TLI_NSRC-1:0] v,
                                                   input logic ext);
    logic [`TLI_DW-1:0] r;
    r = '0;
    if (ext)
    begin
      r[`TLI_EXT_N-1:0] = v[`TLI_NSRC-1:`TLI_MAIN_N];
    end
    else
    begin
      r[`TLI_MAIN_N-1:0] = v[`TLI_MAIN_N-1:0];
    end
    return r;
  endfunction : tli_split

  // ----------------------------------------
  // Request selection
  // ----------------------------------------
  tli_pkg::tli_state_type st_q;
  tli_pkg::tli_state_type st_d;
  logic [`TLI_NSRC-1:0] cand;
  logic [`TLI_NSRC-1:0] hi_set;
  logic [`TLI_NSRC-1:0] lo_set;
  logic [`TLI_NSRC-1:0] pick_set;
  logic [`TLI_NSRC-1:0] pick_one;
  logic [3:0] pick_idx;
  logic hi_ok;
  logic lo_ok;
  logic gate_ok;
  logic take;
  logic [`TLI_NSRC-1:0] sw_set;

  assign cand = st_q.pend & st_q.en;
  assign hi_set = cand & st_q.pri;
  assign lo_set = cand & ~st_q.pri;
  // A high request may nest inside a low routine, never the reverse
  assign hi_ok = !st_q.act_hi && (|hi_set);
  assign lo_ok = !st_q.act_hi && !st_q.act_lo && (|lo_set);
  assign pick_set = hi_ok ? hi_set : (lo_ok ? lo_set : '0);
  assign pick_idx = tli_first_idx(pick_set);
  assign pick_one = `TLI_ONE << pick_idx;
  // Right after a global clear the old enable still counts once, but only
  // when the next instruction is single-cycle; software avoids the race
  assign gate_ok = st_q.global_irq_enable
                 || (st_q.ge_win && !CPU_I.next_multi);
  assign VEC_REQ_O = gate_ok && (hi_ok || lo_ok)
                   && (st_q.phase == tli_pkg::TLI_RUN);
  assign take = CPU_I.instr_done && VEC_REQ_O;
  // Ones written to a pending byte are events of their own
  assign sw_set = !WR_I ? '0
                : (ADDR_I == `TLI_A_PEND_MAIN) ? tli_join('0, WDATA_I, 1'b0)
                : (ADDR_I == `TLI_A_PEND_EXT) ? tli_join('0, WDATA_I, 1'b1)
                : '0;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.call.long_call_vector = 1'b0;
    st_d.rdata = '0;
    if (CPU_I.instr_done)
    begin
      st_d.ge_win = 1'b0;
    end
    if (WR_I)
    begin
      case (ADDR_I)
        `TLI_A_EN_MAIN:
        begin
          st_d.global_irq_enable = WDATA_I[`TLI_GE_BIT];
          if (st_q.global_irq_enable && !WDATA_I[`TLI_GE_BIT])
          begin
            st_d.ge_win = 1'b1;
          end
          st_d.en = tli_join(st_q.en, WDATA_I, 1'b0);
        end
        `TLI_A_EN_EXT:
        begin
          st_d.en = tli_join(st_q.en, WDATA_I, 1'b1);
        end
        `TLI_A_PRI_MAIN:
        begin
          st_d.pri = tli_join(st_q.pri, WDATA_I, 1'b0);
        end
        `TLI_A_PRI_EXT:
        begin
          st_d.pri = tli_join(st_q.pri, WDATA_I, 1'b1);
        end
        `TLI_A_PEND_MAIN:
        begin
          st_d.pend = tli_join(st_q.pend, WDATA_I, 1'b0);
        end
        `TLI_A_PEND_EXT:
        begin
          st_d.pend = tli_join(st_q.pend, WDATA_I, 1'b1);
        end
        `TLI_A_EVT:
        begin
          st_d.evt = st_q.evt & ~WDATA_I[`TLI_NEV-1:0];
        end
        `TLI_A_MASK:
        begin
          st_d.mask = WDATA_I[`TLI_NEV-1:0];
        end
        default:
        begin
        end
      endcase
    end
    if (take)
    begin
      st_d.call.long_call_vector = 1'b1;
      st_d.call.addr = `TLI_VEC_BASE
                     + (`TLI_VW'(pick_idx) << `TLI_VEC_SHIFT);
      st_d.pend = st_d.pend & ~(pick_one & `TLI_AUTO_CLR);
      st_d.evt[`TLI_EV_TAKE] = 1'b1;
      if (hi_ok)
      begin
        st_d.act_hi = 1'b1;
        st_d.evt[`TLI_EV_PRE] = st_d.evt[`TLI_EV_PRE] | st_q.act_lo;
      end
      else
      begin
        st_d.act_lo = 1'b1;
      end
    end
    else if (CPU_I.interrupt_return_instr)
    begin
      // Return closes the innermost level and holds off one instruction
      if (st_q.act_hi)
      begin
        st_d.act_hi = 1'b0;
      end
      else
      begin
        st_d.act_lo = 1'b0;
      end
      st_d.phase = tli_pkg::TLI_HOLD;
      st_d.evt[`TLI_EV_RET] = 1'b1;
    end
    else if (CPU_I.instr_done && (st_q.phase == tli_pkg::TLI_HOLD))
    begin
      st_d.phase = tli_pkg::TLI_RUN;
    end
    // Hardware events win over a software clear in the same cycle, and a
    // software set counts as an event, so it also beats the auto-clear
    st_d.pend = st_d.pend | SRC_EVENT_I | sw_set;
    if (RD_I)
    begin
      case (ADDR_I)
        `TLI_A_EN_MAIN:
        begin
          st_d.rdata = tli_split(st_q.en, 1'b0);
          st_d.rdata[`TLI_GE_BIT] = st_q.global_irq_enable;
        end
        `TLI_A_EN_EXT: st_d.rdata = tli_split(st_q.en, 1'b1);
        `TLI_A_PRI_MAIN: st_d.rdata = tli_split(st_q.pri, 1'b0);
        `TLI_A_PRI_EXT: st_d.rdata = tli_split(st_q.pri, 1'b1);
        `TLI_A_PEND_MAIN: st_d.rdata = tli_split(st_q.pend, 1'b0);
        `TLI_A_PEND_EXT: st_d.rdata = tli_split(st_q.pend, 1'b1);
        `TLI_A_EVT: st_d.rdata = `TLI_DW'(st_q.evt);
        `TLI_A_MASK: st_d.rdata = `TLI_DW'(st_q.mask);
        `TLI_A_LVL:
        begin
          st_d.rdata = `TLI_DW'({st_q.phase == tli_pkg::TLI_HOLD, st_q.act_hi, st_q.act_lo});
        end
        default: st_d.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign RDATA_O = st_q.rdata;
  assign CALL_O = st_q.call;
  assign IRQ_O = |(st_q.evt & st_q.mask);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!ARST_N_I);

  sequence s_take;
    CPU_I.instr_done && VEC_REQ_O;
  endsequence

  sequence s_call;
    CALL_O.long_call_vector;
  endsequence

  sequence s_ret_hold;
    CPU_I.interrupt_return_instr && !take ##1 (st_q.phase == tli_pkg::TLI_HOLD);
  endsequence

  chk_flag_sets: assert property (
    (SRC_EVENT_I != '0) |=> ((st_q.pend & $past(SRC_EVENT_I)) == $past(SRC_EVENT_I)))
    else $error("pending flag not set by event");

  chk_call_follows: assert property (
    s_take |=> s_call ##1 !CALL_O.long_call_vector)
    else $error("vector call missing after take");

  chk_call_cause: assert property (
    s_call |-> $past(CPU_I.instr_done) && ($past(st_q.pend & st_q.en) != '0))
    else $error("call without enabled pending flag");

  chk_global_off: assert property (
    CPU_I.instr_done && !st_q.global_irq_enable && !st_q.ge_win |=> !CALL_O.long_call_vector)
    else $error("call while globally disabled");

  chk_clear_multi: assert property (
    CPU_I.instr_done && !st_q.global_irq_enable && CPU_I.next_multi |=> !CALL_O.long_call_vector)
    else $error("call taken before multi-cycle instruction");

  chk_return_hold: assert property (
    s_ret_hold |-> !VEC_REQ_O ##1 (!CALL_O.long_call_vector))
    else $error("re-entry without one instruction between");

  chk_return_level: assert property (
    CPU_I.interrupt_return_instr && !take && st_q.act_hi |=> !st_q.act_hi && $stable(st_q.act_lo))
    else $error("return did not close high level");

  chk_auto_clear: assert property (
    s_call |-> ((st_q.pend & $past(pick_one) & `TLI_AUTO_CLR
                 & ~$past(SRC_EVENT_I) & ~$past(sw_set)) == '0))
    else $error("auto-clear flag still set after vectoring");

  chk_sw_event: assert property (
    WR_I && (ADDR_I == `TLI_A_PEND_MAIN) |=>
      ((st_q.pend[`TLI_MAIN_N-1:0] & $past(WDATA_I[`TLI_MAIN_N-1:0]))
       == $past(WDATA_I[`TLI_MAIN_N-1:0])))
    else $error("software set of pending flag lost");

  chk_no_nest_hi: assert property (
    s_call |-> !$past(st_q.act_hi))
    else $error("call taken inside high routine");

  chk_vec_addr: assert property (
    s_take |=> (CALL_O.addr == `TLI_VEC_BASE + (`TLI_VW'($past(pick_idx)) << `TLI_VEC_SHIFT)))
    else $error("wrong vector address");

  sequence s_hold_done;
    CPU_I.instr_done && (st_q.phase == tli_pkg::TLI_HOLD) && !CPU_I.interrupt_return_instr;
  endsequence

  chk_hold_release: assert property (
    s_hold_done |=> !CALL_O.long_call_vector && (st_q.phase == tli_pkg::TLI_RUN))
    else $error("hold phase not released after one instruction");

  chk_take_event: assert property (
    s_take |=> st_q.evt[`TLI_EV_TAKE])
    else $error("vector take not recorded in event status");

  chk_preempt_event: assert property (
    CPU_I.instr_done && VEC_REQ_O && hi_ok && st_q.act_lo
    |=> st_q.evt[`TLI_EV_PRE] && st_q.act_hi && st_q.act_lo)
    else $error("high request did not preempt low routine");

  chk_ge_window: assert property (
    WR_I && (ADDR_I == `TLI_A_EN_MAIN) && st_q.global_irq_enable
    && !WDATA_I[`TLI_GE_BIT] |=> st_q.ge_win && !st_q.global_irq_enable)
    else $error("global clear window not opened");

endmodule : tli_handler

//--- hw/tli_params.svh
`ifndef TLI_PARAMS_SVH
`define TLI_PARAMS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define TLI_NSRC 12
`define TLI_AW 4
`define TLI_DW 8
`define TLI_MAIN_N 7
`define TLI_EXT_N 5
`define TLI_NEV 3
`define TLI_VW 16

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TLI_A_EN_MAIN 4'h0
`define TLI_A_EN_EXT 4'h1
`define TLI_A_PRI_MAIN 4'h2
`define TLI_A_PRI_EXT 4'h3
`define TLI_A_PEND_MAIN 4'h4
`define TLI_A_PEND_EXT 4'h5
`define TLI_A_EVT 4'h6
`define TLI_A_MASK 4'h7
`define TLI_A_LVL 4'h8

// ----------------------------------------
// Fields and constants
// ----------------------------------------
`define TLI_GE_BIT 7
`define TLI_EV_TAKE 0
`define TLI_EV_RET 1
`define TLI_EV_PRE 2
`define TLI_AUTO_CLR 12'h005
`define TLI_VEC_BASE 16'h0003
`define TLI_VEC_SHIFT 3
`define TLI_ONE 12'h001

`endif

//--- hw/tli_pkg.sv
`include "tli_params.svh"

package tli_pkg;

  typedef enum logic {TLI_RUN, TLI_HOLD} tli_phase_type;

  typedef struct packed {
    logic instr_done;
    logic next_multi;
    logic interrupt_return_instr;
  } tli_cpu_type;

  typedef struct packed {
    logic long_call_vector;
    logic [`TLI_VW-1:0] addr;
  } tli_call_type;

  typedef struct packed {
    logic [`TLI_NSRC-1:0] en;
    logic [`TLI_NSRC-1:0] pri;
    logic [`TLI_NSRC-1:0] pend;
    logic global_irq_enable;
    logic ge_win;
    logic [`TLI_NEV-1:0] evt;
    logic [`TLI_NEV-1:0] mask;
    logic act_hi;
    logic act_lo;
    tli_phase_type phase;
    tli_call_type call;
    logic [`TLI_DW-1:0] rdata;
  } tli_state_type;

endpackage : tli_pkg

//--- verif/tli_cpu_model.sv
`timescale 1ns/1ns

// ----------------------------------------
// Sequencer model, four-cycle instructions
// ----------------------------------------
module tli_cpu_model (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic multi_i,
  input wire logic ret_i,
  output tli_pkg::tli_cpu_type cpu_o
);
  logic [1:0] cnt_q;
  logic ret_q;
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_q <= 2'h0;
      ret_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + 2'h1;
      if (ret_i)
        ret_q <= 1'b1;
      else if (cnt_q == 2'h1)
        ret_q <= 1'b0;
    end
  end
  // Return lands off the boundary so it never meets a take
  assign cpu_o.instr_done = (cnt_q == 2'h3);
  assign cpu_o.next_multi = multi_i;
  assign cpu_o.interrupt_return_instr = ret_q && (cnt_q == 2'h1);
endmodule : tli_cpu_model

//--- verif/tli_handler_bench.sv
`timescale 1ns/1ns

// ----------------------------------------
// Bench
// ----------------------------------------
module tli_handler_bench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] src = 12'h000;
  logic ret = 1'b0;
  logic multi = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  tli_pkg::tli_call_type call;
  tli_pkg::tli_cpu_type cpu;
  logic irq;
  logic req;
  int miscompares = 0;
  int samples_checked = 0;
  int calls = 0;
  int cyc = 0;
  logic [15:0] last = 16'h0000;

  always #5 clk = ~clk;

  tli_handler tli_handler_inst (
    .CLK_I(clk), .ARST_N_I(arst_n), .SRC_EVENT_I(src), .CPU_I(cpu),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .CALL_O(call), .VEC_REQ_O(req), .IRQ_O(irq)
  );

  tli_cpu_model tli_cpu_model_inst (
    .clk_i(clk), .arst_n_i(arst_n), .multi_i(multi), .ret_i(ret), .cpu_o(cpu)
  );

  task end_of_test;
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // Counting calls here means a pulse is never missed while a task is busy
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (call.long_call_vector === 1'b1)
    begin
      calls <= calls + 1;
      last <= call.addr;
    end
    if (cyc == 3000)
    begin
      miscompares = miscompares + 1;
      end_of_test();
    end
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  task rd_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check({8'h00, rdata}, {8'h00, exp});
  endtask : rd_reg

  task pulse_src(input int i);
    @(posedge clk);
    src <= 12'h001 << i;
    @(posedge clk);
    src <= 12'h000;
  endtask : pulse_src

  task ret_isr;
    @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : ret_isr

  task wait_calls(input int n, input logic [15:0] a);
    repeat (40)
      if (calls < n) @(posedge clk);
    #1;
    check(calls, n);
    check(last, a);
  endtask : wait_calls

  task no_call(input int n);
    repeat (16) @(posedge clk);
    #1;
    check(calls, n);
  endtask : no_call

  task s_reset_values;
    for (int a = 0; a < 10; a++)
      rd_reg(a[3:0], 8'h00);
  endtask : s_reset_values

  task s_gating;
    wr_reg(4'h0, 8'h80);
    pulse_src(4);
    pulse_src(3);
    no_call(0);
    multi <= 1'b1;
    wr_reg(4'h0, 8'h08);
    no_call(0);
    @(posedge clk);
    multi <= 1'b0;
    no_call(0);
    check(req, 1'b0);
    rd_reg(4'h4, 8'h18);
    wr_reg(4'h4, 8'h08);
    wr_reg(4'h0, 8'h88);
    check(req, 1'b1);
    wait_calls(1, 16'h001B);
    rd_reg(4'h4, 8'h08);
  endtask : s_gating

  task s_reentry;
    ret_isr();
    wait_calls(2, 16'h001B);
    wr_reg(4'h4, 8'h00);
    ret_isr();
    no_call(2);
  endtask : s_reentry

  task s_soft_set;
    wr_reg(4'h0, 8'h81);
    wr_reg(4'h4, 8'h01);
    wait_calls(3, 16'h0003);
    rd_reg(4'h4, 8'h00);
    ret_isr();
  endtask : s_soft_set

  task s_irq_ext;
    wr_reg(4'h7, 8'h01);
    check(irq, 1'b1);
    wr_reg(4'h6, 8'h01);
    check(irq, 1'b0);
    wr_reg(4'h1, 8'h01);
    wr_reg(4'h5, 8'h01);
    wait_calls(4, 16'h003B);
    check(irq, 1'b1);
    wr_reg(4'h7, 8'h00);
    check(irq, 1'b0);
    wr_reg(4'h5, 8'h00);
  endtask : s_irq_ext

  task s_preempt;
    wr_reg(4'h2, 8'h02);
    wr_reg(4'h0, 8'h83);
    wr_reg(4'h4, 8'h02);
    wait_calls(5, 16'h000B);
    rd_reg(4'h8, 8'h03);
    rd_reg(4'h6, 8'h07);
    wr_reg(4'h4, 8'h00);
    ret_isr();
    ret_isr();
    no_call(5);
  endtask : s_preempt

  // Clear the global enable in the cycle a flag rises: the window still takes it
  task s_clear_window;
    @(posedge clk);
    addr <= 4'h0;
    wdata <= 8'h01;
    wr <= 1'b1;
    src <= 12'h001;
    @(posedge clk);
    wr <= 1'b0;
    src <= 12'h000;
    wait_calls(6, 16'h0003);
    rd_reg(4'h0, 8'h01);
    ret_isr();
    no_call(6);
  endtask : s_clear_window

  initial
  begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    s_reset_values();
    s_gating();
    s_reentry();
    s_soft_set();
    s_irq_ext();
    s_preempt();
    s_clear_window();
    end_of_test();
  end
endmodule : tli_handler_bench
